/* rtl/dshp_device.sv */
// dshp_device: sensor-side serial port (spi 4/3-wire and i2c slave)
// assumes: register bank outside, read data valid the cycle after rd strobe
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// - spi modes 00 and 11 auto selected
// - 4-wire after reset; 0x34 bit selects 3-wire
// - 3-wire uses data-in pin both ways
// - single access is one 16-bit transfer
// - host frames with chip select, drives clock
// - drive on falling, sample on rising
// - serial out high-z during writes
// - first bit is direction flag
// - bits 1-7 address, 8-15 data
// - burst read increments address per byte
// - host idles after every write
// - i2c slave, 7-bit addressing only
// - accel i2c address 0x18 or 0x19
// - gyro i2c address 0x68 or 0x69
// - start condition makes bus busy
// - stop condition returns slave idle
// - every byte acknowledged, line held low
// - protocol pin low spi, high i2c
// - i2c write: addr, reg, data, stop
// - i2c reads from last address, auto-increment
// - watchdog resets hung i2c slave
module dshp_device #(
  parameter int unsigned WDT_SHORT = dshp_pkg::WDT_SHORT_CYC,
  parameter int unsigned WDT_LONG = dshp_pkg::WDT_LONG_CYC
) (
  // system
  input wire logic clock_i,
  input wire logic resetn_i,
  // link
  dshp_if.device link,
  // register bank side
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic reg_gyro_o,
  output logic [6:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] cfg_acc_o,
  output logic [7:0] cfg_gyr_o
);
  // two-flop synchronisers: ps, clk, data, csa, csg, adra, adrg
  logic [6:0] s1_q, s2_q, s3_q;
  logic [6:0] pin_w;
  assign pin_w = {link.gyro_out_or_addr_pin, link.accel_out_or_addr_pin,
                  link.gyro_chip_sel_n, link.accel_chip_sel_n,
                  link.shared_data_pin, link.shared_clock_pin, link.protocol_select_pin};
  logic ps, ck, sd, csa, csg, ck_p, sd_p, cs_n, cs_p;
  assign ps = s2_q[0];
  assign ck = s2_q[1];
  assign sd = s2_q[2];
  assign csa = s2_q[3];
  assign csg = s2_q[4];
  assign ck_p = s3_q[1];
  assign sd_p = s3_q[2];
  assign cs_n = csa & csg;
  assign cs_p = s3_q[3] & s3_q[4];
  logic ck_rise, ck_fall, cs_fall;
  assign ck_rise = ck & !ck_p;
  assign ck_fall = !ck & ck_p;
  assign cs_fall = !cs_n & cs_p;

  dshp_pkg::dshp_spi_st_t sst_q, sst_d;
  dshp_pkg::dshp_i2c_st_t ist_q, ist_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic [3:0] cnt_q, cnt_d;
  logic rd_q, rd_d, gy_q, gy_d, cpol_q, cpol_d, drv_q, drv_d, dout_q, dout_d;
  logic [6:0] addr_q, addr_d, ia_acc_q, ia_acc_d, ia_gyr_q, ia_gyr_d;
  logic [7:0] cfa_q, cfa_d, cfg_q, cfg_d;
  logic wr_d, rdp_d, wr_q, rdp_q, load_q, load_d, first_q, first_d, nack_q, nack_d;
  logic ld2_q, ld2_d;
  logic [31:0] wdt_q, wdt_d;
  logic three_w;

  // 3-wire only when set in the addressed target's map
  assign three_w = gy_q ? cfg_q[dshp_pkg::CFG_3WIRE_BIT] : cfa_q[dshp_pkg::CFG_3WIRE_BIT];

  function automatic logic [6:0] nxt(input logic [6:0] a);
    nxt = a + 7'h01;
  endfunction : nxt

  always_comb begin
    sst_d = sst_q; ist_d = ist_q; sh_d = sh_q; tx_d = tx_q; cnt_d = cnt_q;
    rd_d = rd_q; gy_d = gy_q; cpol_d = cpol_q; drv_d = drv_q; dout_d = dout_q;
    addr_d = addr_q; ia_acc_d = ia_acc_q; ia_gyr_d = ia_gyr_q;
    cfa_d = cfa_q; cfg_d = cfg_q; wr_d = 1'b0; rdp_d = 1'b0; load_d = 1'b0;
    first_d = first_q; nack_d = nack_q; wdt_d = 32'h0;
    // bank answers the cycle after the strobe, so take its data one cycle later
    ld2_d = load_q;
    if (ld2_q) tx_d = reg_rdata_i;
    if (wr_q && addr_q == dshp_pkg::REG_IF_CONF) begin
      if (gy_q) cfg_d = sh_q;
      else cfa_d = sh_q;
    end
    // protocol pin picks spi or i2c
    if (!ps) begin
      ist_d = dshp_pkg::DSHP_I2C_IDLE;
      if (cs_n) begin
        sst_d = dshp_pkg::DSHP_SPI_IDLE;
        drv_d = 1'b0;
      end else if (cs_fall) begin
        cpol_d = ck;
        gy_d = !csg;
        sst_d = dshp_pkg::DSHP_SPI_CTRL;
        cnt_d = 4'h0;
      end else if (ck_rise) begin
        // sample on rising edge, msb first
        sh_d = {sh_q[6:0], sd};
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(dshp_pkg::SPI_CTRL_BITS - 1)) begin
          if (sst_q == dshp_pkg::DSHP_SPI_CTRL) begin
            rd_d = sh_q[6];
            addr_d = {sh_q[5:0], sd};
            sst_d = dshp_pkg::DSHP_SPI_DATA;
            rdp_d = sh_q[6];
            load_d = sh_q[6];
          end else if (rd_q) begin
            addr_d = nxt(addr_q);
            rdp_d = 1'b1;
            load_d = 1'b1;
          end else begin
            wr_d = 1'b1;
            sh_d = {sh_q[6:0], sd};
          end
          cnt_d = 4'h0;
        end
      end else if (ck_fall && sst_q == dshp_pkg::DSHP_SPI_DATA && rd_q) begin
        // drive on falling edge; only reads drive
        drv_d = 1'b1;
        dout_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end else begin
      sst_d = dshp_pkg::DSHP_SPI_IDLE;
      // watchdog counts while slave holds the line
      if (drv_q && cfa_q[dshp_pkg::CFG_WDT_EN_BIT]) wdt_d = wdt_q + 32'h1;
      if (ck && ck_p && sd_p && !sd) begin
        ist_d = dshp_pkg::DSHP_I2C_ADDR;
        cnt_d = 4'h0;
        drv_d = 1'b0;
        first_d = 1'b1;
      end else if (ck && ck_p && !sd_p && sd) begin
        ist_d = dshp_pkg::DSHP_I2C_IDLE;
        drv_d = 1'b0;
      end else if (wdt_q >= (cfa_q[dshp_pkg::CFG_WDT_SEL_BIT] ? WDT_LONG : WDT_SHORT)) begin
        ist_d = dshp_pkg::DSHP_I2C_IDLE;
        drv_d = 1'b0;
      end else if (ck_rise) begin
        unique case (ist_q)
          dshp_pkg::DSHP_I2C_ADDR, dshp_pkg::DSHP_I2C_RX: begin
            sh_d = {sh_q[6:0], sd};
            cnt_d = cnt_q + 4'h1;
          end
          dshp_pkg::DSHP_I2C_MACK: nack_d = sd;
          default: ;
        endcase
      end else if (ck_fall) begin
        unique case (ist_q)
          dshp_pkg::DSHP_I2C_ADDR: if (cnt_q == 4'(dshp_pkg::BYTE_BITS)) begin
            if (sh_q[7:1] == {dshp_pkg::I2C_ACC_BASE[6:1], s2_q[5]} ||
                sh_q[7:1] == {dshp_pkg::I2C_GYR_BASE[6:1], s2_q[6]}) begin
              gy_d = sh_q[7:1] == {dshp_pkg::I2C_GYR_BASE[6:1], s2_q[6]};
              rd_d = sh_q[0];
              drv_d = 1'b1;
              dout_d = 1'b0;
              ist_d = dshp_pkg::DSHP_I2C_ACK;
              // read starts at last written address
              addr_d = gy_d ? ia_gyr_q : ia_acc_q;
              rdp_d = sh_q[0];
              load_d = sh_q[0];
            end else ist_d = dshp_pkg::DSHP_I2C_IDLE;
          end
          dshp_pkg::DSHP_I2C_RX: if (cnt_q == 4'(dshp_pkg::BYTE_BITS)) begin
            drv_d = 1'b1;
            dout_d = 1'b0;
            ist_d = dshp_pkg::DSHP_I2C_ACK;
            // first byte register address, then data
            if (first_q) begin
              addr_d = sh_q[6:0];
              if (gy_q) ia_gyr_d = sh_q[6:0];
              else ia_acc_d = sh_q[6:0];
              first_d = 1'b0;
            end else wr_d = 1'b1;
          end
          dshp_pkg::DSHP_I2C_ACK, dshp_pkg::DSHP_I2C_MACK: begin
            cnt_d = 4'h0;
            if (rd_q && !(ist_q == dshp_pkg::DSHP_I2C_MACK && nack_q)) begin
              ist_d = dshp_pkg::DSHP_I2C_TX;
              drv_d = 1'b1;
              dout_d = tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = 4'h1;
            end else if (rd_q) begin
              ist_d = dshp_pkg::DSHP_I2C_IDLE;
              drv_d = 1'b0;
            end else begin
              ist_d = dshp_pkg::DSHP_I2C_RX;
              drv_d = 1'b0;
            end
          end
          dshp_pkg::DSHP_I2C_TX: begin
            if (cnt_q == 4'(dshp_pkg::BYTE_BITS)) begin
              drv_d = 1'b0;
              ist_d = dshp_pkg::DSHP_I2C_MACK;
              addr_d = nxt(addr_q);
              rdp_d = 1'b1;
              load_d = 1'b1;
            end else begin
              dout_d = tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= 7'h7F; s2_q <= 7'h7F; s3_q <= 7'h7F;
      sst_q <= dshp_pkg::DSHP_SPI_IDLE; ist_q <= dshp_pkg::DSHP_I2C_IDLE;
      sh_q <= 8'h00; tx_q <= 8'h00; cnt_q <= 4'h0; rd_q <= 1'b0; gy_q <= 1'b0;
      cpol_q <= 1'b0; drv_q <= 1'b0; dout_q <= 1'b1; addr_q <= 7'h00;
      ia_acc_q <= dshp_pkg::I2C_ADDR_RESET; ia_gyr_q <= dshp_pkg::I2C_ADDR_RESET;
      cfa_q <= dshp_pkg::CFG_RESET; cfg_q <= dshp_pkg::CFG_RESET;
      wr_q <= 1'b0; rdp_q <= 1'b0; load_q <= 1'b0; first_q <= 1'b0;
      nack_q <= 1'b0; wdt_q <= 32'h0; ld2_q <= 1'b0;
    end else begin
      s1_q <= pin_w; s2_q <= s1_q; s3_q <= s2_q;
      sst_q <= sst_d; ist_q <= ist_d; sh_q <= sh_d; tx_q <= tx_d; cnt_q <= cnt_d;
      rd_q <= rd_d; gy_q <= gy_d; cpol_q <= cpol_d; drv_q <= drv_d; dout_q <= dout_d;
      addr_q <= addr_d; ia_acc_q <= ia_acc_d; ia_gyr_q <= ia_gyr_d;
      cfa_q <= cfa_d; cfg_q <= cfg_d; wr_q <= wr_d; rdp_q <= rdp_d;
      load_q <= load_d; first_q <= first_d; nack_q <= nack_d; wdt_q <= wdt_d;
      ld2_q <= ld2_d;
    end
  end

  assign reg_wr_o = wr_q;
  assign reg_rd_o = rdp_q;
  assign reg_gyro_o = gy_q;
  assign reg_addr_o = addr_q;
  assign reg_wdata_o = sh_q;
  assign cfg_acc_o = cfa_q;
  assign cfg_gyr_o = cfg_q;
  // 3-wire reads turn the data-in pin round; i2c always uses it
  assign link.dev_sd_o = dout_q;
  assign link.dev_sd_oe_n = !(drv_q && (ps || three_w));
  assign link.dev_out_o = dout_q;
  assign link.dev_out_oe_n = !(drv_q && !ps && !three_w);
endmodule : dshp_device

/* rtl/dshp_host.sv */
// dshp_host: host controller driving the sensor port, axi4-lite slave
// assumes: one command at a time; software polls the busy bit
`timescale 1ns/1ps
module dshp_host (
  // system
  input wire logic clock_i,
  input wire logic resetn_i,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // link
  dshp_if.host link
);
  logic [31:0] ctrl_q, ctrl_d, cmd_q, cmd_d, rd_q, rd_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, busy_q, busy_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] wd_q, wd_d, rdat_q, rdat_d;
  logic [5:0] bit_q, bit_d;
  logic [7:0] div_q, div_d;
  logic sck_q, sck_d, cs_q, cs_d, so_q, so_d;
  logic [15:0] sh_q, sh_d;
  logic [31:0] idle_q, idle_d;
  logic [1:0] si1_q, si2_q;
  // ctrl: bit0 gyro target, bit1 mode11, bit2 3-wire, bit3 suspend idle, bit4 i2c
  // cmd: [31] start, [15:0] frame (read flag, address, data)
  assign awready = !aw_q;
  assign wready = !w_q;
  assign bvalid = bv_q;
  assign bresp = 2'b00;
  assign arready = !rv_q;
  assign rvalid = rv_q;
  assign rdata = rdat_q;
  assign rresp = 2'b00;

  always_comb begin
    ctrl_d = ctrl_q; cmd_d = cmd_q; rd_d = rd_q; aw_d = aw_q; w_d = w_q;
    bv_d = bv_q; rv_d = rv_q; wa_d = wa_q; wd_d = wd_q; rdat_d = rdat_q;
    busy_d = busy_q; bit_d = bit_q; div_d = div_q; sck_d = sck_q; cs_d = cs_q;
    so_d = so_q; sh_d = sh_q;
    idle_d = (idle_q != 32'h0) ? idle_q - 32'h1 : 32'h0;
    if (awvalid && awready) begin aw_d = 1'b1; wa_d = awaddr; end
    if (wvalid && wready) begin w_d = 1'b1; wd_d = wdata; end
    if (aw_q && w_q && !bv_q) begin
      bv_d = 1'b1; aw_d = 1'b0; w_d = 1'b0;
      if (wa_q == dshp_pkg::HR_CTRL) ctrl_d = wd_q;
      if (wa_q == dshp_pkg::HR_CMD && !busy_q && wd_q[dshp_pkg::CMD_START_BIT]) begin
        cmd_d = wd_q; busy_d = 1'b1; sh_d = wd_q[15:0]; bit_d = 6'h0;
      end
    end
    if (bv_q && bready) bv_d = 1'b0;
    if (arvalid && arready) begin
      rv_d = 1'b1;
      unique case (araddr)
        dshp_pkg::HR_CTRL: rdat_d = ctrl_q;
        dshp_pkg::HR_CMD: rdat_d = cmd_q;
        dshp_pkg::HR_STATUS: rdat_d = {31'h0, busy_q};
        dshp_pkg::HR_RDATA: rdat_d = rd_q;
        default: rdat_d = 32'h0;
      endcase
    end
    if (rv_q && rready) rv_d = 1'b0;
    // idle clock level settles while deselected, never at the select edge
    if (cs_q) sck_d = ctrl_q[1];
    // host frames and clocks; waits out the idle time first
    if (busy_q && idle_q == 32'h0) begin
      if (cs_q) begin
        cs_d = 1'b0; sck_d = ctrl_q[1]; div_d = 8'h0; so_d = sh_q[15];
      end else if (div_q == 8'(dshp_pkg::SCK_HALF_CYC - 1)) begin
        div_d = 8'h0;
        // sample half a clock after the rise: both sync chains eat the first half
        if (sck_q && bit_q != 6'h0) rd_d = {rd_q[30:0], si2_q[ctrl_q[2] ? 1 : 0]};
        if (bit_q == 6'(dshp_pkg::SPI_FRAME_BITS)) begin
          cs_d = 1'b1; busy_d = 1'b0; sck_d = ctrl_q[1];
          if (!cmd_q[15]) idle_d = ctrl_q[3] ? 32'(dshp_pkg::IDLE_SUS_CYC)
                                            : 32'(dshp_pkg::IDLE_NM_CYC);
        end else begin
          sck_d = !sck_q;
          // count on rising; shift on falling, but not the lead fall of mode 11
          if (!sck_q) begin
            bit_d = bit_q + 6'h1;
          end else if (bit_q != 6'h0) begin
            sh_d = {sh_q[14:0], 1'b0};
            so_d = sh_q[14];
          end
        end
      end else div_d = div_q + 8'h1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= 32'h0; cmd_q <= 32'h0; rd_q <= 32'h0; aw_q <= 1'b0; w_q <= 1'b0;
      bv_q <= 1'b0; rv_q <= 1'b0; wa_q <= 8'h00; wd_q <= 32'h0; rdat_q <= 32'h0;
      busy_q <= 1'b0; bit_q <= 6'h0; div_q <= 8'h0; sck_q <= 1'b1; cs_q <= 1'b1;
      so_q <= 1'b1; sh_q <= 16'h0; idle_q <= 32'h0; si1_q <= 2'b11; si2_q <= 2'b11;
    end else begin
      ctrl_q <= ctrl_d; cmd_q <= cmd_d; rd_q <= rd_d; aw_q <= aw_d; w_q <= w_d;
      bv_q <= bv_d; rv_q <= rv_d; wa_q <= wa_d; wd_q <= wd_d; rdat_q <= rdat_d;
      busy_q <= busy_d; bit_q <= bit_d; div_q <= div_d; sck_q <= sck_d; cs_q <= cs_d;
      so_q <= so_d; sh_q <= sh_d; idle_q <= idle_d;
      si1_q <= {link.shared_data_pin, ctrl_q[0] ? link.gyro_out_or_addr_pin
                                                 : link.accel_out_or_addr_pin};
      si2_q <= si1_q;
    end
  end

  // host straps spi; i2c select kept as ctrl bit
  assign link.protocol_select_pin = ctrl_q[4];
  assign link.shared_clock_pin = sck_q;
  assign link.accel_chip_sel_n = cs_q | ctrl_q[0];
  assign link.gyro_chip_sel_n = cs_q | !ctrl_q[0];
  // in 3-wire reads the host releases the line for the data byte
  assign link.host_sd_o = so_q;
  // let go only after the fall that ends the control byte, so its last bit is seen
  assign link.host_sd_oe_n = cs_q | (ctrl_q[2] && cmd_q[15] &&
                             (bit_q > 6'(dshp_pkg::SPI_CTRL_BITS) ||
                              (bit_q == 6'(dshp_pkg::SPI_CTRL_BITS) && !sck_q)));
endmodule : dshp_host

/* rtl/dshp_if.sv */
// dshp_if: the shared pins between host controller and sensor port
// assumes: interface resolves the shared data pin from the two enables, released drives read high
`timescale 1ns/1ps
interface dshp_if;
  logic protocol_select_pin;
  logic shared_clock_pin;
  logic accel_chip_sel_n;
  logic gyro_chip_sel_n;
  // shared data pin: host drive, device drive, resolved level
  logic shared_data_pin;
  logic host_sd_o;
  logic host_sd_oe_n;
  logic dev_sd_o;
  logic dev_sd_oe_n;
  // per-target serial out / i2c address select
  logic accel_out_or_addr_pin;
  logic gyro_out_or_addr_pin;
  logic dev_out_o;
  logic dev_out_oe_n;
  assign shared_data_pin = (!host_sd_oe_n ? host_sd_o : 1'b1) &
                           (!dev_sd_oe_n ? dev_sd_o : 1'b1);
  modport device (
    input protocol_select_pin, shared_clock_pin, accel_chip_sel_n, gyro_chip_sel_n,
    input shared_data_pin, accel_out_or_addr_pin, gyro_out_or_addr_pin,
    output dev_sd_o, dev_sd_oe_n, dev_out_o, dev_out_oe_n
  );
  modport host (
    output protocol_select_pin, shared_clock_pin, accel_chip_sel_n, gyro_chip_sel_n,
    output host_sd_o, host_sd_oe_n,
    input shared_data_pin, accel_out_or_addr_pin, gyro_out_or_addr_pin
  );
endinterface : dshp_if

/* rtl/dshp_pkg.sv */
// dshp_pkg: constants shared by both ends of the dual serial host port
// assumes: single 100 MHz system clock on both ends, link pins sampled
package dshp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // register map of the sensor targets (7-bit address space)
  localparam logic [6:0] REG_IF_CONF = 7'h34;
  localparam int unsigned CFG_3WIRE_BIT = 0;
  localparam int unsigned CFG_WDT_SEL_BIT = 1;
  localparam int unsigned CFG_WDT_EN_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [6:0] I2C_ADDR_RESET = 7'h00;
  // i2c target addresses; lsb comes from the address-select pin
  localparam logic [6:0] I2C_ACC_BASE = 7'h18;
  localparam logic [6:0] I2C_GYR_BASE = 7'h68;
  // spi frame layout
  localparam int unsigned SPI_CTRL_BITS = 8;
  localparam int unsigned SPI_FRAME_BITS = 16;
  localparam int unsigned BYTE_BITS = 8;
  // watchdog periods
  localparam int unsigned WDT_SHORT_US = 1000;
  localparam int unsigned WDT_LONG_US = 50000;
  localparam int unsigned WDT_SHORT_CYC = WDT_SHORT_US * CLK_MHZ;
  localparam int unsigned WDT_LONG_CYC = WDT_LONG_US * CLK_MHZ;
  // host post-write idle
  localparam int unsigned IDLE_NM_US = 2;
  localparam int unsigned IDLE_SUS_US = 450;
  localparam int unsigned IDLE_NM_CYC = IDLE_NM_US * CLK_MHZ;
  localparam int unsigned IDLE_SUS_CYC = IDLE_SUS_US * CLK_MHZ;
  // host serial clock divider: half period in system clocks (80 ns period)
  localparam int unsigned SCK_HALF_CYC = 4;
  localparam int unsigned SCL_HALF_CYC = 125;
  // host register bank (axi4-lite byte offsets)
  localparam logic [7:0] HR_CTRL = 8'h00;
  localparam logic [7:0] HR_CMD = 8'h04;
  localparam logic [7:0] HR_STATUS = 8'h08;
  localparam logic [7:0] HR_RDATA = 8'h0C;
  localparam int unsigned CMD_START_BIT = 31;
  typedef enum logic [2:0] {
    DSHP_SPI_IDLE = 3'b000,
    DSHP_SPI_CTRL = 3'b001,
    DSHP_SPI_DATA = 3'b010
  } dshp_spi_st_t;
  typedef enum logic [2:0] {
    DSHP_I2C_IDLE = 3'b000,
    DSHP_I2C_ADDR = 3'b001,
    DSHP_I2C_ACK = 3'b010,
    DSHP_I2C_RX = 3'b011,
    DSHP_I2C_TX = 3'b100,
    DSHP_I2C_MACK = 3'b101
  } dshp_i2c_st_t;
endpackage : dshp_pkg

/* tb/dshp_assertions.sv */
// dshp_assertions: spi link checks between host controller and sensor port
// assumes: link pins sampled on the 100 MHz system clock, spi traffic only
`timescale 1ns/1ps
module dshp_assertions (
  // system
  input wire logic clock_i,
  input wire logic resetn_i,
  // link
  input wire logic shared_clock_pin,
  input wire logic accel_chip_sel_n,
  input wire logic gyro_chip_sel_n,
  input wire logic shared_data_pin,
  input wire logic host_sd_o,
  input wire logic host_sd_oe_n,
  input wire logic dev_sd_oe_n,
  input wire logic dev_out_oe_n
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic sel;
  logic sck_q;
  logic rw_q;
  logic [5:0] bits_q;
  logic [15:0] gap_q;
  assign sel = !accel_chip_sel_n || !gyro_chip_sel_n;
  // count rising serial clocks in a frame; first bit is the direction
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_q <= 1'b1;
      bits_q <= 6'h00;
      rw_q <= 1'b0;
      gap_q <= 16'hFFFF;
    end else begin
      sck_q <= shared_clock_pin;
      if (sel) begin
        gap_q <= 16'h0000;
      end else if (gap_q != 16'hFFFF) begin
        gap_q <= gap_q + 16'h0001;
      end
      if (!sel) begin
        bits_q <= 6'h00;
      end else if (shared_clock_pin && !sck_q) begin
        bits_q <= bits_q + 6'h01;
        if (bits_q == 6'h00) begin
          rw_q <= shared_data_pin;
        end
      end
    end
  end
  property p_one_target; !(!accel_chip_sel_n && !gyro_chip_sel_n); endproperty
  a_one_target: assert property (p_one_target) else $error("two targets selected");
  property p_quiet; (!sel)[*4] |-> dev_out_oe_n && dev_sd_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("device drives while deselected");
  property p_no_contend; !(!dev_sd_oe_n && !host_sd_oe_n); endproperty
  a_no_contend: assert property (p_no_contend) else $error("data pin driven twice");
  property p_read_only; !dev_out_oe_n || !dev_sd_oe_n |-> rw_q; endproperty
  a_read_only: assert property (p_read_only) else $error("device drives in write");
  property p_after_ctrl; $fell(dev_out_oe_n && dev_sd_oe_n) |-> sel && bits_q >= 6'h08;
  endproperty
  a_after_ctrl: assert property (p_after_ctrl) else $error("drive before data field");
  property p_write_len; $fell(sel) && !rw_q |-> bits_q == 6'h10; endproperty
  a_write_len: assert property (p_write_len) else $error("write frame not 16 bits");
  property p_bytes; $fell(sel) |-> bits_q >= 6'h10 && bits_q[2:0] == 3'h0; endproperty
  a_bytes: assert property (p_bytes) else $error("frame not whole bytes");
  property p_host_stable;
    sel && $rose(shared_clock_pin) && !host_sd_oe_n |-> $stable(host_sd_o);
  endproperty
  a_host_stable: assert property (p_host_stable) else $error("data moved at rise");
  property p_write_idle;
    $rose(sel) && !rw_q |-> gap_q >= 16'(dshp_pkg::IDLE_NM_CYC);
  endproperty
  a_write_idle: assert property (p_write_idle) else $error("frame too soon after write");
endmodule : dshp_assertions

/* tb/dual_serial_host_port_tb_top.sv */
// dual_serial_host_port_tb_top: host controller and sensor port joined over spi
// assumes: bench models the sensor register bank and masters axi4-lite
`timescale 1ns/1ps
module dual_serial_host_port_tb_top;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, reg_rdata_i = 8'h00;
  logic [31:0] wdata = 32'h00000000, seed = 32'h00012A8D, r, rdata;
  logic awready, wready, bvalid, arready, rvalid, reg_wr_o, reg_rd_o, reg_gyro_o;
  logic tgl = 1'b0, mode = 1'b0, wire3 = 1'b0;
  logic [1:0] bresp, rresp;
  logic [6:0] reg_addr_o;
  logic [7:0] reg_wdata_o, cfg_acc_o, cfg_gyr_o, q;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  int errors = 0, checks = 0, cyc = 0;
  dshp_if link_if ();
  always #5 clock_i = ~clock_i;
  // a released serial out toggles so a stale bit never reads as data
  assign link_if.accel_out_or_addr_pin = !link_if.dev_out_oe_n ? link_if.dev_out_o : tgl;
  assign link_if.gyro_out_or_addr_pin = !link_if.dev_out_oe_n ? link_if.dev_out_o : tgl;
  dshp_host dshp_host_inst (.clock_i(clock_i), .resetn_i(resetn_i), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .link(link_if.host));
  dshp_device #(.WDT_SHORT(50), .WDT_LONG(200)) dshp_device_inst (.clock_i(clock_i),
    .resetn_i(resetn_i), .link(link_if.device), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .reg_gyro_o(reg_gyro_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .reg_rdata_i(reg_rdata_i), .cfg_acc_o(cfg_acc_o), .cfg_gyr_o(cfg_gyr_o));
  dshp_assertions dshp_assertions_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .shared_clock_pin(link_if.shared_clock_pin), .accel_chip_sel_n(link_if.accel_chip_sel_n),
    .gyro_chip_sel_n(link_if.gyro_chip_sel_n), .shared_data_pin(link_if.shared_data_pin),
    .host_sd_o(link_if.host_sd_o), .host_sd_oe_n(link_if.host_sd_oe_n),
    .dev_sd_oe_n(link_if.dev_sd_oe_n), .dev_out_oe_n(link_if.dev_out_oe_n));
  // register bank stand-in: read data one cycle after the strobe
  always @(posedge clock_i) begin
    tgl <= ~tgl;
    if (reg_wr_o) mem[{reg_gyro_o, reg_addr_o}] <= reg_wdata_o;
    if (reg_rd_o) reg_rdata_i <= mem[{reg_gyro_o, reg_addr_o}];
    cyc++;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [31:0] cmd(input logic rd, input logic [6:0] a, input logic [7:0] d);
    return {1'b1, 15'h0000, rd, a, d};
  endfunction : cmd
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks++;
    if (seen !== expv) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    @(posedge clock_i);
    aw_done = 1'b0;
    w_done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock_i);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock_i); while (!bvalid);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock_i);
    d = rdata;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wait_idle;
    logic [31:0] s;
    do axi_rd(dshp_pkg::HR_STATUS, s); while (s[0] !== 1'b0);
  endtask : wait_idle
  task automatic frame(input logic g, input logic rd, input logic [6:0] a, input logic [7:0] d);
    axi_wr(dshp_pkg::HR_CTRL, {29'h00000000, wire3, mode, g});
    axi_wr(dshp_pkg::HR_CMD, cmd(rd, a, d));
    if (!rd) exp_mem[{g, a}] = d;
    wait_idle();
    axi_rd(dshp_pkg::HR_RDATA, r);
    q = r[7:0];
  endtask : frame
  // random write, read back, then the same address on the other target
  task automatic pairs;
    logic g;
    logic [6:0] a;
    for (int i = 0; i < 6; i++) begin
      mode = i[0];
      seed = xs(seed);
      g = seed[0];
      a = 7'(seed[15:8] % 8'h34);
      frame(g, 1'b0, a, seed[31:24]);
      frame(g, 1'b1, a, 8'h00);
      check(q, exp_mem[{g, a}]);
      frame(!g, 1'b1, a, 8'h00);
      check(q, exp_mem[{!g, a}]);
    end
  endtask : pairs
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
      exp_mem[i] = 8'(i) ^ 8'hA5;
    end
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    check(cfg_acc_o, dshp_pkg::CFG_RESET);
    pairs();
    axi_wr(dshp_pkg::HR_CTRL, 32'h00000000);
    axi_wr(dshp_pkg::HR_CMD, cmd(1'b0, 7'h10, seed[7:0]));
    exp_mem[8'h10] = seed[7:0];
    axi_wr(dshp_pkg::HR_CMD, cmd(1'b0, 7'h11, seed[15:8]));
    wait_idle();
    frame(1'b0, 1'b1, 7'h11, 8'h00);
    check(q, exp_mem[8'h11]);
    frame(1'b0, 1'b1, 7'h10, 8'h00);
    check(q, exp_mem[8'h10]);
    frame(1'b0, 1'b0, dshp_pkg::REG_IF_CONF, 8'h01);
    frame(1'b1, 1'b0, dshp_pkg::REG_IF_CONF, 8'h01);
    check(cfg_acc_o, 8'h01);
    check(cfg_gyr_o, 8'h01);
    wire3 = 1'b1;
    pairs();
    frame(1'b0, 1'b0, dshp_pkg::REG_IF_CONF, 8'h00);
    frame(1'b1, 1'b0, dshp_pkg::REG_IF_CONF, 8'h00);
    check(cfg_gyr_o, 8'h00);
    check(cfg_acc_o, 8'h00);
    wire3 = 1'b0;
    pairs();
    axi_rd(8'hF0, r);
    conclude();
  end
endmodule : dual_serial_host_port_tb_top
